// File: rtl/fsl_pkg.sv
// Constants, register map and types for the flyback mode selector
package fsl_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1000000;
	localparam int unsigned BURST_SW_NS     = 50000;
	localparam int unsigned BURST_SW_CYC    = BURST_SW_NS * CYC_PER_US / 1000;
	localparam int unsigned LEB_NS          = 480;
	localparam int unsigned LEB_CYC         = (LEB_NS * CYC_PER_US + 999) / 1000;
	localparam int unsigned HALF_PERIOD_US  = 9823;
	localparam int unsigned HALF_PERIOD_CYC = HALF_PERIOD_US * CYC_PER_US;
	localparam int unsigned VALLEY_WAIT_CYC = 1000;
	// Feedback levels in mV
	localparam logic [11:0] FB_ON_MV    = 12'h4b0;
	localparam logic [11:0] FB_BURST_MV = 12'h320;
	localparam logic [11:0] FB_SW_MV    = 12'h7d0;
	localparam logic [11:0] CEIL_END_MV = 12'h97c;
	localparam int unsigned MAP_RECIP   = (1 << 20) / (2000 - 800);
	// Register byte offsets
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_BURST     = 8'h04;
	localparam logic [7:0] REG_BURST_REP = 8'h08;
	localparam logic [7:0] REG_FB_LEVELS = 8'h0c;
	localparam logic [7:0] REG_CEIL_STEP = 8'h10;
	localparam logic [7:0] REG_TON_MIN   = 8'h14;
	localparam logic [7:0] REG_TON_MAX   = 8'h18;
	localparam logic [7:0] REG_DEMAG     = 8'h1c;
	localparam logic [7:0] REG_VOUT      = 8'h20;
	localparam logic [7:0] REG_VIN_RANGE = 8'h24;
	localparam logic [7:0] REG_VIN_OV    = 8'h28;
	localparam logic [7:0] REG_OCP       = 8'h2c;
	localparam logic [7:0] REG_TSW_MIN   = 8'h30;
	localparam logic [7:0] REG_STATUS    = 8'h34;
	localparam logic [7:0] REG_LIMITS    = 8'h38;
	localparam logic [7:0] REG_OCP_NOW   = 8'h3c;
	localparam int unsigned NUM_CFG      = 13;
	// Writable bits and reset values of the configuration words
	localparam logic [31:0] CFG_MASK [NUM_CFG] = '{
		32'h0000_0003, 32'h00ff_ffff, 32'h000f_ffff, 32'h0fff_0fff,
		32'h0000_0fff, 32'h0fff_0fff, 32'h00ff_ffff, 32'hffff_0fff,
		32'h00ff_0fff, 32'h0fff_0fff, 32'h0000_0fff, 32'h0fff_0fff,
		32'h0000_0fff};
	localparam logic [31:0] CFG_RESET [NUM_CFG] = '{
		32'h0000_0000, 32'h0004_2710, 32'h0003_0d40, 32'h0898_02bc,
		32'h0000_0010, 32'h000a_0019, 32'h0004_01f4, 32'h0100_0064,
		32'h0080_0bb8, 32'h0bb8_05dc, 32'h0000_0e10, 32'h0320_0400,
		32'h0000_0064};
	// On-time and current limits refreshed once per half period
	typedef struct packed {
		logic [15:0] ton_min;
		logic [15:0] ton_max;
		logic [11:0] ocp;
	} fsl_limits_t;
	typedef enum logic [1:0] {FSL_OFF, FSL_DCM, FSL_QR, FSL_BURST} fsl_mode_t;
endpackage

// File: rtl/fsl_top.sv
// Flyback mode selector, switching limits and gate timing with APB registers
//
// Behaviour
// RULE1 - In quasi-resonant mode switch on at the first auxiliary valley.
// RULE2 - Feedback at least 1.2 V and short period gives quasi-resonant mode.
// RULE3 - In discontinuous mode switch on at a valley after the first.
// RULE4 - Between 0.8 V and 1.2 V run discontinuous, adapted minimum on-time.
// RULE5 - At 1.2 V up with long period stay discontinuous, regulate both.
// RULE6 - Feedback below 0.8 V for blanking time enters burst mode.
// RULE7 - Burst switching period fixed at 50 us; burst rate from config.
// RULE8 - Burst pulses and on-time from feedback at previous burst's last pulse.
// RULE9 - Feedback above 0.8 V in burst returns to regulated switching.
// RULE10 - At or below floor use burst minimum on-time and minimum pulses.
// RULE11 - Burst disables output protections; input ones only when enabled.
// RULE12 - Sensing minimum on-time is demag times ratio times OV over peak.
// RULE13 - Regulated minimum on-time is larger of configured and sensing value.
// RULE14 - Within input range maximum on-time scales by low level over input.
// RULE15 - Below low level maximum on-time folds back by gain times shortfall.
// RULE16 - On-time limits update once per line half-period or 9.823 ms.
// RULE17 - Minimum period shrinks from 50 us to 1/fmax over 0.8 to 2.0 V.
// RULE18 - Current limit interpolates across input range, clamped at ends.
// RULE19 - At max-map level on-time is maximum, bounded by current limit.
// RULE20 - Current comparison ignored for 480 ns after switch turn-on.
// RULE21 - Current limit recomputed once per line half-period.
// RULE22 - Feedback ceiling ramps 1.2 V to 2.428 V by step per half-period.
// RULE23 - Map from ceiling while feedback exceeds it, else from feedback.
// RULE24 - All comparisons and interpolation digital in one clocked loop.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module fsl_top
	import fsl_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_PERIOD_CYC  // Fallback half period
) (
	input  wire logic        pclk,             // System clock
	input  wire logic        presetn,          // Async reset, active low
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB enable
	input  wire logic        pwrite,           // APB write
	input  wire logic [7:0]  paddr,            // APB byte address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error, unmapped
	input  wire logic [11:0] filtered_feedback,// Feedback, mV
	input  wire logic [11:0] vin_est,          // Estimated input voltage
	input  wire logic [11:0] vin_peak,         // Estimated input peak
	input  wire logic [11:0] cs_level,         // Current-sense sample
	input  wire logic        aux_valley,       // Valley pulse, aux winding
	input  wire logic        line_sync_valid,  // Line sync established
	input  wire logic        line_half_tick,   // Synced half-period pulse
	output logic             gate_drive,       // Power switch gate
	output logic [1:0]       op_mode,          // Current operating mode
	output logic             out_protect_en,   // Output protections on
	output logic             in_protect_en     // Input protections on
);
	logic [31:0] cfg [NUM_CFG];
	fsl_mode_t   mode;
	fsl_limits_t lim;
	logic [11:0] ceiling;
	logic        reg_en_d;
	logic [19:0] half_cnt;
	logic [15:0] blank_cnt;
	logic [19:0] rep_cnt;
	logic [7:0]  pulses_left;
	logic [11:0] burst_fb;
	logic [15:0] sw_cnt;
	logic [15:0] on_cnt;
	logic [15:0] ton_cur;
	logic [15:0] qr_period;
	logic        valley_seen;
	logic [1:0]  div_op;
	logic        div_busy;
	logic [5:0]  div_cnt;
	logic [32:0] div_rem;
	logic [31:0] div_q;
	logic [15:0] div_den;

	// Configuration fields
	wire        regulate_en      = cfg[0][0];
	wire        burst_input_protect_enable = cfg[0][1];
	wire [15:0] burst_entry_blanking = cfg[1][15:0];
	wire [7:0]  min_burst_pulses = cfg[1][23:16];
	wire [19:0] burst_rep_cyc    = cfg[2][19:0];
	wire [11:0] feedback_floor   = cfg[3][11:0];
	wire [11:0] max_power_map_level = cfg[3][27:16];
	wire [11:0] ceiling_step     = cfg[4][11:0];
	wire [11:0] ton_min_cfg      = cfg[5][11:0];
	wire [11:0] ton_min_burst    = cfg[5][27:16];
	wire [15:0] ton_max_low      = cfg[6][15:0];
	wire [7:0]  on_gain          = cfg[6][23:16];
	wire [11:0] min_demag        = cfg[7][11:0];
	wire [15:0] turns_ratio      = cfg[7][31:16];
	wire [11:0] vout_ov          = cfg[8][11:0];
	wire [7:0]  foldback_gain    = cfg[8][23:16];
	wire [11:0] vin_low          = cfg[9][11:0];
	wire [11:0] vin_high         = cfg[9][27:16];
	wire [11:0] vin_ov           = cfg[10][11:0];
	wire [11:0] ocp_low          = cfg[11][11:0];
	wire [11:0] ocp_high         = cfg[11][27:16];
	wire [11:0] tsw_min          = cfg[12][11:0];

	// APB decode
	wire        apb_setup  = psel && !penable;
	wire        apb_write  = psel && penable && pready && pwrite;
	wire [5:0]  word_idx   = paddr[7:2];
	wire        cfg_hit    = paddr[1:0] == 2'b00 && word_idx < 6'(NUM_CFG);
	wire        ro_hit     = paddr == REG_STATUS || paddr == REG_LIMITS ||
	                         paddr == REG_OCP_NOW;
	wire [31:0] status_word = {4'h0, ceiling, 14'h0, mode};
	wire [31:0] rd_value;
	assign rd_value = cfg_hit ? cfg[word_idx[3:0]] :
	                  paddr == REG_STATUS ? status_word :
	                  paddr == REG_LIMITS ? {lim.ton_max, lim.ton_min} :
	                  paddr == REG_OCP_NOW ? {20'h0, lim.ocp} : 32'h0;

	// Half-period tick: synced line, else internal fallback [RULE16]
	wire int_tick  = half_cnt == 20'(HALF_CYC - 1);
	wire half_tick = line_sync_valid ? line_half_tick : int_tick;

	// Feedback used for mapping, capped by the start-up ceiling [RULE23]
	wire [11:0] fb_eff = (filtered_feedback > ceiling) ? ceiling :
	                     filtered_feedback;
	wire [11:0] ceil_sum  = ceiling + ceiling_step;
	wire        ceil_done = ceil_sum > CEIL_END_MV || ceil_sum < ceiling;

	// Minimum period falls linearly with feedback [RULE17]
	wire [11:0] sw_span  = 12'(BURST_SW_CYC) - tsw_min;
	wire [11:0] fb_above = fb_eff - FB_BURST_MV;
	wire [43:0] per_prod = 44'(sw_span) * 44'(fb_above) * 44'(MAP_RECIP);
	wire [15:0] min_period = (fb_eff <= FB_BURST_MV) ? 16'(BURST_SW_CYC) :
	                         (fb_eff >= FB_SW_MV) ? 16'(tsw_min) :
	                         16'(BURST_SW_CYC) - 16'(per_prod[31:20]);

	// Mode choice from feedback and measured first-valley period
	wire fb_low   = fb_eff < FB_BURST_MV;
	wire qr_fits  = fb_eff >= FB_ON_MV && min_period < qr_period; // [RULE2]
	wire [15:0] blank_next = (blank_cnt == 16'hffff) ? blank_cnt :
	                         blank_cnt + 16'h1;

	// On-time demand in regulated modes [RULE4] [RULE5] [RULE19]
	wire [23:0] ton_ramp = 24'(fb_eff - FB_ON_MV) * 24'(on_gain) +
	                       24'(lim.ton_min);
	wire [15:0] ton_reg = (fb_eff >= max_power_map_level) ? lim.ton_max :
	                      (fb_eff <= FB_ON_MV) ? lim.ton_min :
	                      (ton_ramp > 24'(lim.ton_max)) ? lim.ton_max :
	                      ton_ramp[15:0];

	// Burst pulses and on-time from latched feedback [RULE8] [RULE10]
	wire        at_floor  = burst_fb <= feedback_floor;
	wire [11:0] fb_excess = burst_fb - feedback_floor;
	wire [8:0]  pulse_sum = 9'(min_burst_pulses) + 9'(fb_excess[11:5]);
	wire [7:0]  burst_pulses = at_floor ? min_burst_pulses :
	                           pulse_sum[8] ? 8'hff : pulse_sum[7:0];
	wire [23:0] burst_ramp = 24'(fb_excess) * 24'(on_gain) +
	                         24'(ton_min_burst);
	wire [15:0] ton_burst = at_floor ? 16'(ton_min_burst) :
	                        (burst_ramp > 24'(lim.ton_max)) ? lim.ton_max :
	                        burst_ramp[15:0];

	// Switch-on decision per mode [RULE1] [RULE3] [RULE7]
	wire period_ok = sw_cnt >= min_period;
	wire wait_out  = sw_cnt >= min_period + 16'(VALLEY_WAIT_CYC);
	wire on_qr     = period_ok && (aux_valley || wait_out);
	wire on_dcm    = period_ok && ((aux_valley && valley_seen) || wait_out);
	wire on_burst  = pulses_left != 8'h0 && sw_cnt >= 16'(BURST_SW_CYC);
	wire turn_on   = !gate_drive && (mode == FSL_QR ? on_qr :
	                 mode == FSL_DCM ? on_dcm :
	                 mode == FSL_BURST ? on_burst : 1'b0);
	wire rep_wrap  = rep_cnt >= burst_rep_cyc;

	// Turn-off on on-time or current limit after blanking [RULE19] [RULE20]
	wire cs_trip  = on_cnt >= 16'(LEB_CYC) && cs_level >= lim.ocp;
	wire turn_off = gate_drive && (on_cnt >= ton_cur || cs_trip ||
	                mode == FSL_OFF);

	// Divider operands for the three limit calculations [RULE24]
	wire [11:0] vin_c    = (vin_est > vin_ov) ? vin_ov : vin_est;
	wire        vin_under = vin_est < vin_low;
	wire [39:0] sense_num = 40'(min_demag) * 40'(turns_ratio) *
	                        40'(vout_ov);                     // [RULE12]
	wire [27:0] tmax_num  = 28'(ton_max_low) * 28'(vin_low);  // [RULE14]
	wire [35:0] fold_num  = 36'(ton_max_low) * 36'(foldback_gain) *
	                        36'(vin_low - vin_est);           // [RULE15]
	wire        ocp_down  = ocp_low >= ocp_high;
	wire [11:0] ocp_diff  = ocp_down ? ocp_low - ocp_high :
	                        ocp_high - ocp_low;
	wire [23:0] ocp_num   = 24'(ocp_diff) * 24'(vin_est - vin_low);
	wire [31:0] op_num = (div_op == 2'd0) ? sense_num[39:8] :
	                     (div_op == 2'd1) ? (vin_under ?
	                     32'(fold_num[35:8]) : 32'(tmax_num)) :
	                     32'(ocp_num);
	wire [15:0] op_den = (div_op == 2'd0) ? 16'(vin_peak) :
	                     (div_op == 2'd1) ? (vin_under ? 16'(vin_low) :
	                     16'(vin_c)) : 16'(vin_high - vin_low);
	wire [32:0] rem_sh  = {div_rem[31:0], div_q[31]};
	wire        sub_ok  = rem_sh >= 33'(div_den);
	wire        div_end = div_busy && div_cnt == 6'd0;

	// Results of each finished division
	wire [15:0] q_sat   = (div_q[31:16] != 16'h0) ? 16'hffff : div_q[15:0];
	wire [15:0] tmin_eff = (q_sat > 16'(ton_min_cfg)) ? q_sat :
	                       16'(ton_min_cfg);                  // [RULE13]
	wire [15:0] tmax_fold = (q_sat > ton_max_low) ? 16'h0 :
	                        ton_max_low - q_sat;
	wire [11:0] q_ocp   = (div_q[31:12] != 20'h0) ? 12'hfff : div_q[11:0];
	wire [11:0] ocp_lin = ocp_down ? ocp_low - q_ocp : ocp_low + q_ocp;
	wire [11:0] ocp_new = (vin_est <= vin_low) ? ocp_low :
	                      (vin_est >= vin_high) ? ocp_high :
	                      ocp_lin;                            // [RULE18]

	// APB registers; answer with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !cfg_hit && !ro_hit;
			if (apb_setup)
				prdata <= pwrite ? 32'h0 : rd_value;
		end
	end

	// Configuration words, reserved bits held at zero
	generate
		for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					cfg[i] <= CFG_RESET[i];
				else if (apb_write && cfg_hit && word_idx == 6'(i))
					cfg[i] <= pwdata & CFG_MASK[i];
			end
		end
	endgenerate

	// Internal half-period counter, runs without line sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			half_cnt <= 20'h0;
		else if (int_tick || line_half_tick)
			half_cnt <= 20'h0;
		else
			half_cnt <= half_cnt + 20'h1;
	end

	// Mode state; a disable drops back to off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode      <= FSL_OFF;
			blank_cnt <= 16'h0;
		end else if (!regulate_en) begin
			mode      <= FSL_OFF;
			blank_cnt <= 16'h0;
		end else begin
			case (mode)
				FSL_OFF: begin
					mode <= FSL_DCM;
				end
				FSL_DCM, FSL_QR: begin
					blank_cnt <= fb_low ? blank_next : 16'h0;
					if (fb_low && blank_cnt >= burst_entry_blanking)
						mode <= FSL_BURST;                    // [RULE6]
					else if (qr_fits)
						mode <= FSL_QR;                       // [RULE2]
					else
						mode <= FSL_DCM;                      // [RULE4] [RULE5]
				end
				FSL_BURST: begin
					blank_cnt <= 16'h0;
					if (fb_eff > FB_BURST_MV)
						mode <= qr_fits ? FSL_QR : FSL_DCM;   // [RULE9]
				end
				default: mode <= FSL_OFF;
			endcase
		end
	end

	// Start-up ceiling ramp on entry to regulation [RULE22]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ceiling  <= FB_ON_MV;
			reg_en_d <= 1'b0;
		end else begin
			reg_en_d <= regulate_en;
			if (regulate_en && !reg_en_d)
				ceiling <= FB_ON_MV;
			else if (regulate_en && half_tick)
				ceiling <= ceil_done ? CEIL_END_MV : ceil_sum;
		end
	end

	// Burst repetition and pulse bookkeeping [RULE7] [RULE8]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rep_cnt     <= 20'h0;
			pulses_left <= 8'h0;
			burst_fb    <= 12'h0;
		end else if (mode != FSL_BURST) begin
			rep_cnt     <= 20'h0;
			pulses_left <= 8'h0;
			burst_fb    <= feedback_floor;
		end else begin
			rep_cnt <= rep_wrap ? 20'h0 : rep_cnt + 20'h1;
			if (rep_wrap)
				pulses_left <= burst_pulses;
			else if (turn_on)
				pulses_left <= pulses_left - 8'h1;
			if (turn_on && pulses_left == 8'h1)
				burst_fb <= filtered_feedback;
		end
	end

	// Gate timing and first-valley measurement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_drive  <= 1'b0;
			sw_cnt      <= 16'h0;
			on_cnt      <= 16'h0;
			ton_cur     <= 16'h0;
			qr_period   <= 16'hffff;
			valley_seen <= 1'b0;
		end else if (turn_on) begin
			gate_drive  <= 1'b1;
			sw_cnt      <= 16'h0;
			on_cnt      <= 16'h0;
			valley_seen <= 1'b0;
			ton_cur     <= (mode == FSL_BURST) ? ton_burst : ton_reg;
		end else begin
			sw_cnt <= (sw_cnt == 16'hffff) ? sw_cnt : sw_cnt + 16'h1;
			on_cnt <= gate_drive ? on_cnt + 16'h1 : 16'h0;
			if (turn_off)
				gate_drive <= 1'b0;
			// Only the first valley after demag sets the reference period
			if (!gate_drive && aux_valley && !valley_seen) begin
				valley_seen <= 1'b1;
				qr_period   <= sw_cnt;
			end
		end
	end

	// Shared serial divider, three operations per half period
	// One divider keeps area small; limits lag a tick by about 100 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_op   <= 2'd0;
			div_busy <= 1'b0;
			div_cnt  <= 6'd0;
			div_rem  <= 33'h0;
			div_q    <= 32'h0;
			div_den  <= 16'h0;
		end else if (!div_busy && (half_tick || div_op != 2'd0)) begin
			div_busy <= 1'b1;
			div_cnt  <= 6'd32;
			div_rem  <= 33'h0;
			div_q    <= op_num;
			div_den  <= (op_den == 16'h0) ? 16'h1 : op_den;
		end else if (div_end) begin
			div_busy <= 1'b0;
			div_op   <= (div_op == 2'd2) ? 2'd0 : div_op + 2'd1;
		end else if (div_busy) begin
			div_cnt <= div_cnt - 6'd1;
			div_rem <= sub_ok ? rem_sh - 33'(div_den) : rem_sh;
			div_q   <= {div_q[30:0], sub_ok};
		end
	end

	// Limits taken when each division ends [RULE16] [RULE21]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim.ton_min <= 16'h0;
			lim.ton_max <= 16'h0;
			lim.ocp     <= 12'h0;
		end else if (div_end) begin
			case (div_op)
				2'd0: lim.ton_min <= tmin_eff;                      // [RULE13]
				2'd1: lim.ton_max <= vin_under ? tmax_fold : q_sat; // [RULE14]
				default: lim.ocp <= ocp_new;                        // [RULE18]
			endcase
		end
	end

	// Mode and protection outputs [RULE11]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_mode        <= 2'b00;
			out_protect_en <= 1'b0;
			in_protect_en  <= 1'b0;
		end else begin
			op_mode        <= mode;
			out_protect_en <= mode == FSL_DCM || mode == FSL_QR;
			in_protect_en  <= mode == FSL_DCM || mode == FSL_QR ||
			                  (mode == FSL_BURST && burst_input_protect_enable);
		end
	end
endmodule

// File: verif/fsl_chk_assertions.sv
// Port checks for the flyback mode selector
`timescale 1ns/1ps
module fsl_chk
	import fsl_pkg::*;
(
	input wire logic        pclk,              // Clock
	input wire logic        presetn,           // Reset, active low
	input wire logic        psel,              // APB select
	input wire logic        penable,           // APB enable
	input wire logic [7:0]  paddr,             // APB address
	input wire logic        pready,            // APB ready
	input wire logic        pslverr,           // APB error
	input wire logic [11:0] filtered_feedback, // Feedback
	input wire logic        aux_valley,        // Valley pulse
	input wire logic        gate_drive,        // Gate
	input wire logic [1:0]  op_mode,           // Mode
	input wire logic        out_protect_en     // Output protections
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] sw_cyc; // Cycles since last turn-on
	logic [3:0]  vcnt;   // Valleys seen since last turn-on
	logic        g_q;    // Gate one cycle ago
	logic        brst_q; // Previous turn-on was in burst
	wire         rise = gate_drive && !g_q;
	// Counters saturate so a long idle cannot wrap into a false failure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g_q <= 1'b0;
			sw_cyc <= 16'hffff;
			vcnt <= 4'h0;
			brst_q <= 1'b0;
		end else begin
			g_q <= gate_drive;
			if (rise) begin
				sw_cyc <= 16'h0000;
				vcnt <= 4'h0;
				brst_q <= (op_mode == 2'd3);
			end else begin
				if (sw_cyc != 16'hffff)
					sw_cyc <= sw_cyc + 16'h0001;
				if (aux_valley && !gate_drive && vcnt != 4'hf)
					vcnt <= vcnt + 4'h1;
			end
		end
	end
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_APB_ERR: assert property (psel && !penable &&
		(paddr > 8'h3c || paddr[1:0] != 2'b00) |=> pready && pslverr)
		else $error("unmapped access not flagged");
	AST_LEB: assert property ($rose(gate_drive) |-> gate_drive [*8])
		else $error("gate cut inside blanking");
	AST_QR_VALLEY: assert property ($rose(gate_drive) &&
		$past(op_mode) == 2'd2 |-> $past(aux_valley) || sw_cyc > 16'd1000)
		else $error("quasi-resonant turn-on off valley");
	AST_DCM_LATE: assert property ($rose(gate_drive) &&
		$past(op_mode) == 2'd1 |->
		($past(aux_valley) && vcnt >= 4'd2) || sw_cyc > 16'd1000)
		else $error("discontinuous turn-on at first valley");
	AST_BURST_GAP: assert property ($rose(gate_drive) &&
		$past(op_mode) == 2'd3 && brst_q |-> sw_cyc >= 16'd2499)
		else $error("burst pulses too close");
	AST_BURST_IN: assert property ($rose(op_mode == 2'd3) |->
		$past(filtered_feedback, 2) < FB_BURST_MV)
		else $error("burst entered with high feedback");
	AST_BURST_OUT: assert property ($fell(op_mode == 2'd3) &&
		op_mode != 2'd0 |-> $past(filtered_feedback, 2) > FB_BURST_MV)
		else $error("burst left with low feedback");
	AST_BURST_PROT: assert property (op_mode == 2'd3 &&
		$past(op_mode) == 2'd3 |-> !out_protect_en)
		else $error("output protection on in burst");
	COV_BURST: cover property (op_mode == 2'd3);
	COV_QR: cover property (op_mode == 2'd2);
	COV_ERR: cover property (pslverr);
endmodule
bind fsl_top fsl_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.filtered_feedback(filtered_feedback), .aux_valley(aux_valley),
	.gate_drive(gate_drive), .op_mode(op_mode),
	.out_protect_en(out_protect_en));

// File: verif/fsl_stage.sv
// Behavioural switch and transformer stage
`timescale 1ns/1ps
module fsl_stage #(
	parameter int unsigned DEMAG = 60, // Cycles to demagnetise
	parameter int unsigned RING  = 40, // Ringing period, cycles
	parameter int unsigned SLOPE = 4   // Sense rise per on-cycle
) (
	input  wire logic        pclk,       // Clock
	input  wire logic        presetn,    // Reset, active low
	input  wire logic        gate_drive, // Gate from controller
	output logic             aux_valley, // Valley pulse
	output logic [11:0]      cs_level    // Current sense
);
	logic [15:0] t_off; // Cycles since switch-off
	// Ringing lasts while off, so late valleys stay available
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_off <= 16'h0;
			aux_valley <= 1'b0;
			cs_level <= 12'h0;
		end else begin
			t_off <= gate_drive ? 16'h0 : t_off + 16'h1;
			aux_valley <= !gate_drive && t_off >= DEMAG &&
				(t_off - DEMAG) % RING == 0;
			cs_level <= gate_drive ? cs_level + 12'(SLOPE) : 12'h0;
		end
	end
endmodule

// File: verif/flyback_mode_and_switching_limits_bench.sv
// Self-checking bench for the flyback mode selector
`timescale 1ns/1ps
module flyback_mode_and_switching_limits_bench
	import fsl_pkg::*;
;
	`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
		n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        lsv = 0, tick = 0, gq = 0, er;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, gate_drive, aux_valley, op, ip;
	logic [1:0]  op_mode;
	logic [11:0] fb = 0, vin = 12'hbb8, vpk = 12'hfa0, cs;
	int          n_errors = 0, comparisons = 0, cyc = 0;
	int          gap = 0, cnt = 0, last_n = 0;
	fsl_top #(.HALF_CYC(200)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .filtered_feedback(fb), .vin_est(vin),
		.vin_peak(vpk), .cs_level(cs), .aux_valley(aux_valley),
		.line_sync_valid(lsv), .line_half_tick(tick),
		.gate_drive(gate_drive), .op_mode(op_mode),
		.out_protect_en(op), .in_protect_en(ip));
	fsl_stage st_u (.pclk(pclk), .presetn(presetn),
		.gate_drive(gate_drive), .aux_valley(aux_valley), .cs_level(cs));
	initial begin
		forever #10 pclk = ~pclk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			test_done();
		end
	end
	// Pulses per burst; a long off gap marks a new burst
	always @(posedge pclk) begin
		gq <= gate_drive;
		gap <= gate_drive ? 0 : gap + 1;
		if (gate_drive && !gq) begin
			last_n <= (gap > 3000) ? cnt : last_n;
			cnt <= (gap > 3000) ? 1 : cnt + 1;
		end
	end
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready is judged with its pre-edge value, as the master sees it
		@(posedge pclk iff (pready === 1'b1));
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse;
		@(posedge pclk);
		tick <= 1'b1;
		@(posedge pclk);
		tick <= 1'b0;
		repeat (150) @(posedge pclk);
	endtask
	// Sensing floor: demag 100 x ratio 1.0 x OV 3000 over peak
	function automatic logic [15:0] e_tmin(input logic [11:0] pk);
		int s;
		s = 300000 / pk;
		return 16'(s > 25 ? s : 25);
	endfunction
	// 500 cycles at low input 1500, scaled by low over input
	function automatic logic [15:0] e_tmax(input logic [11:0] v);
		return 16'(750000 / v);
	endfunction
	initial begin
		void'($urandom(32'h9f4f4880));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < NUM_CFG; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK("cfg reset", CFG_RESET[i], rd)
		end
		for (int i = 1; i < NUM_CFG; i++) begin
			apb(1'b1, 8'(4 * i), 32'hffff_ffff);
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK("cfg mask", CFG_MASK[i], rd)
			apb(1'b1, 8'(4 * i), CFG_RESET[i]);
		end
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, er)
		apb(1'b1, REG_STATUS, 32'hffff_ffff);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("status mode", 2'b00, rd[1:0])
		$display("test registers done");
		apb(1'b1, REG_BURST, 32'h0002_0064);
		apb(1'b1, REG_BURST_REP, 32'h0000_2328);
		apb(1'b1, REG_CEIL_STEP, 32'h0000_0100);
		fb <= 12'd1000;
		repeat (400) @(posedge pclk);
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (3000) @(posedge pclk);
		`CHK("dcm mode", 2'd1, op_mode)
		`CHK("out prot", 1'b1, op)
		fb <= 12'd2428;
		repeat (2000) @(posedge pclk);
		`CHK("qr mode", 2'd2, op_mode)
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("ceiling", CEIL_END_MV, rd[27:16])
		fb <= 12'd1300;
		repeat (5000) @(posedge pclk);
		`CHK("long period", 2'd1, op_mode)
		$display("test modes done");
		lsv <= 1'b1;
		repeat (3) begin
			vin <= 12'(3000 + $urandom % 600);
			vpk <= 12'(1000 + $urandom % 3001);
			pulse();
			apb(1'b0, REG_LIMITS, 32'h0);
			`CHK("ton lim", {e_tmax(vin), e_tmin(vpk)}, rd)
			apb(1'b0, REG_OCP_NOW, 32'h0);
			`CHK("ocp high", 32'h320, rd)
		end
		vin <= 12'd1000;
		repeat (300) @(posedge pclk);
		apb(1'b0, REG_OCP_NOW, 32'h0);
		`CHK("ocp held", 32'h320, rd)
		pulse();
		apb(1'b0, REG_OCP_NOW, 32'h0);
		`CHK("ocp low", 32'h400, rd)
		apb(1'b0, REG_LIMITS, 32'h0);
		// 500 x (1 - 0.5 x 500 / 1500), truncated shortfall term
		`CHK("ton fold", 16'd417, rd[31:16])
		vin <= 12'hbb8;
		pulse();
		$display("test limits done");
		fb <= 12'd500;
		repeat (20000) @(posedge pclk);
		`CHK("burst mode", 2'd3, op_mode)
		`CHK("burst oprot", 1'b0, op)
		`CHK("burst iprot", 1'b0, ip)
		`CHK("min pulses", 2, last_n)
		apb(1'b1, REG_CTRL, 32'h3);
		repeat (5) @(posedge pclk);
		`CHK("burst iprot on", 1'b1, ip)
		fb <= 12'd732;
		repeat (27000) @(posedge pclk);
		`CHK("burst pulses", 3, last_n)
		fb <= 12'd1000;
		repeat (100) @(posedge pclk);
		`CHK("burst exit", 2'd1, op_mode)
		$display("test burst done");
		test_done();
	end
endmodule
